//--- servo_ctl_pkg.sv
/*
 * Shared constants for the servo mode and stop controller: APB register map,
 * reset values, mode and stop-method codes, controller states, timing.
 * Assumes a 250 MHz pclk and a 32-bit APB master.
 */
// Behaviour
// - Mode selector takes 0..7: pos, speed, torque, three pairs, triple, special.
// - Triple selection: toggle 1 gives position, else toggle 0 torque, else speed.
// - Drive enables when the servo-enable input becomes active.
// - Commands accepted only while the servo-ready output is asserted.
// - Stop on enable removal, fault, or emergency stop input.
// - Enable removal, emergency stop and fault each have their own stop method.
// - Enable removal: 0 coast off, 1 fast ramp then off, 2 slow ramp then off.
// - Emergency stop takes 0..4; 3 and 4 ramp fast/slow and stay enabled.
// - A stop that stays enabled locks out commands until enable is removed.
// - Coast stop switches power output off at once.
// - Ramped stops keep power on while speed ramps down.
// - Fast stop time 0..65535 ms, default 500.
// - Slow stop time 0..65535 ms, default 1000.
// - Ramp duration equals set time times current speed over rated speed.
package servo_ctl_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_MODE_SEL   = 8'h00;
    localparam logic [7:0] ADDR_DIS_METHOD = 8'h04;
    localparam logic [7:0] ADDR_EST_METHOD = 8'h08;
    localparam logic [7:0] ADDR_FLT_METHOD = 8'h0c;
    localparam logic [7:0] ADDR_FAST_TIME  = 8'h10;
    localparam logic [7:0] ADDR_SLOW_TIME  = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;
    localparam logic [7:0] ADDR_SPEED      = 8'h1c;

    // Reset values and legal maxima
    localparam logic [15:0] RST_MODE_SEL  = 16'h0000;
    localparam logic [15:0] RST_METHOD    = 16'h0000;
    localparam logic [15:0] RST_FAST_TIME = 16'h01f4;
    localparam logic [15:0] RST_SLOW_TIME = 16'h03e8;
    localparam logic [15:0] MAX_MODE_SEL  = 16'h0007;
    localparam logic [15:0] MAX_DIS_METH  = 16'h0002;
    localparam logic [15:0] MAX_EST_METH  = 16'h0004;

    // Mode selector codes
    localparam logic [2:0] SEL_POS     = 3'h0;
    localparam logic [2:0] SEL_SPD     = 3'h1;
    localparam logic [2:0] SEL_TRQ     = 3'h2;
    localparam logic [2:0] SEL_POS_TRQ = 3'h3;
    localparam logic [2:0] SEL_POS_SPD = 3'h4;
    localparam logic [2:0] SEL_TRQ_SPD = 3'h5;
    localparam logic [2:0] SEL_TRIPLE  = 3'h6;

    // Resolved working mode
    typedef enum logic [1:0] {
        MODE_POS = 2'b00,
        MODE_SPD = 2'b01,
        MODE_TRQ = 2'b10,
        MODE_SPC = 2'b11
    } work_mode_t;

    // Stop methods
    localparam logic [2:0] METH_COAST     = 3'h0;
    localparam logic [2:0] METH_FAST_OFF  = 3'h1;
    localparam logic [2:0] METH_SLOW_OFF  = 3'h2;
    localparam logic [2:0] METH_FAST_HOLD = 3'h3;
    localparam logic [2:0] METH_SLOW_HOLD = 3'h4;

    // Stop causes
    typedef enum logic [1:0] {
        CAUSE_NONE  = 2'b00,
        CAUSE_DIS   = 2'b01,
        CAUSE_ESTOP = 2'b10,
        CAUSE_FAULT = 2'b11
    } cause_t;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN  = 3'b001,
        ST_RAMP = 3'b010,
        ST_HOLD = 3'b011,
        ST_HALT = 3'b100
    } ctl_state_t;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_IN_NS      = 1000000;
    localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
    localparam int RATED_RPM     = 3000;

endpackage : servo_ctl_pkg

//--- stop_ramp.sv
/*
 * Deceleration ramp: counts the speed reference from its loaded value down
 * to zero at rated speed per programmed time.
 * Assumes time_ms may change mid-ramp and takes the new slope at once.
 */
`timescale 1ns/1ns
module stop_ramp #(
    parameter int SPW        = 16,
    parameter int RATED      = servo_ctl_pkg::RATED_RPM,
    parameter int CYC_PER_MS = servo_ctl_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Control
    input  wire logic           load,
    input  wire logic           run,
    input  wire logic [SPW-1:0] speed_in,
    input  wire logic [15:0]    time_ms,
    // Result
    output logic [SPW-1:0]      speed_r,
    output logic                done_r
);
    localparam logic [39:0] RATED_W = 40'(RATED);
    localparam logic [23:0] CPM_W   = 24'(CYC_PER_MS);

    logic [39:0] acc_r;
    logic [39:0] span;
    logic [39:0] acc_nxt;

    // One rpm step per span/RATED cycles: whole ramp is time * speed / rated
    assign span    = 40'(time_ms) * 40'(CPM_W);
    assign acc_nxt = acc_r + RATED_W;

    // Speed count and fractional accumulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_r <= '0;
            acc_r   <= '0;
        end else if (load) begin
            speed_r <= speed_in;
            acc_r   <= '0;
        end else if (run && speed_r != '0) begin
            if (span == '0) begin
                speed_r <= '0;
            end else if (acc_nxt >= span) begin
                // Limitation: at most one rpm per cycle
                acc_r   <= acc_nxt - span;
                speed_r <= speed_r - SPW'(1);
            end else begin
                acc_r   <= acc_nxt;
            end
        end
    end

    // Standstill flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= run && !load && speed_r == '0;
        end
    end

endmodule : stop_ramp

//--- servo_mode_stop.sv
/*
 * Servo mode selection and enable/stop sequencing with an APB register file.
 * Assumes asynchronous level inputs for enable, emergency stop, fault and
 * mode toggles, and a speed feedback word from logic on pclk.
 */
`timescale 1ns/1ns
module servo_mode_stop #(
    parameter int SPW        = 16,
    parameter int RATED      = servo_ctl_pkg::RATED_RPM,
    parameter int CYC_PER_MS = servo_ctl_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Input function bits (asynchronous)
    input  wire logic           servo_enable_input,
    input  wire logic           emergency_stop_input,
    input  wire logic           fault_input,
    input  wire logic           mode_toggle_0,
    input  wire logic           mode_toggle_1,
    // Motor side
    input  wire logic [SPW-1:0] speed_feedback,
    output logic                servo_ready_output,
    output logic                cmd_accept,
    output logic                power_output_on,
    output logic                cmd_locked,
    output logic [1:0]          active_mode,
    output logic [SPW-1:0]      ramp_speed
);
    logic [4:0]  sync1_r;
    logic [4:0]  sync2_r;
    logic        en_s;
    logic        est_s;
    logic        flt_s;
    logic        tog0_s;
    logic        tog1_s;
    logic [2:0]  mode_sel_r;
    logic [2:0]  dis_meth_r;
    logic [2:0]  est_meth_r;
    logic [2:0]  flt_meth_r;
    logic [15:0] fast_time_r;
    logic [15:0] slow_time_r;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    logic [31:0] rd_nxt;
    servo_ctl_pkg::ctl_state_t state_r;
    servo_ctl_pkg::ctl_state_t state_nxt;
    servo_ctl_pkg::cause_t     cause_r;
    servo_ctl_pkg::cause_t     cause_nxt;
    servo_ctl_pkg::cause_t     new_cause;
    servo_ctl_pkg::work_mode_t mode_nxt;
    logic [2:0]  meth;
    logic [2:0]  new_meth;
    logic        ramp_load;
    logic        ramp_done;
    logic [15:0] ramp_time;

    // Two-flop synchronisers for all pin inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {mode_toggle_1, mode_toggle_0, fault_input,
                        emergency_stop_input, servo_enable_input};
            sync2_r <= sync1_r;
        end
    end
    assign {tog1_s, tog0_s, flt_s, est_s, en_s} = sync2_r;

    // APB decode; zero wait states, answer one cycle after setup
    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pready && pwrite && !pslverr;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= servo_ctl_pkg::ADDR_SPEED;

    // Settings; out-of-range values are ignored and the old value stays
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_sel_r  <= 3'(servo_ctl_pkg::RST_MODE_SEL);
            dis_meth_r  <= 3'(servo_ctl_pkg::RST_METHOD);
            est_meth_r  <= 3'(servo_ctl_pkg::RST_METHOD);
            flt_meth_r  <= 3'(servo_ctl_pkg::RST_METHOD);
            fast_time_r <= servo_ctl_pkg::RST_FAST_TIME;
            slow_time_r <= servo_ctl_pkg::RST_SLOW_TIME;
        end else if (wr_en) begin
            unique case (paddr)
                servo_ctl_pkg::ADDR_MODE_SEL: begin
                    if (pwdata[15:0] <= servo_ctl_pkg::MAX_MODE_SEL) begin
                        mode_sel_r <= pwdata[2:0];
                    end
                end
                servo_ctl_pkg::ADDR_DIS_METHOD: begin
                    if (pwdata[15:0] <= servo_ctl_pkg::MAX_DIS_METH) begin
                        dis_meth_r <= pwdata[2:0];
                    end
                end
                servo_ctl_pkg::ADDR_EST_METHOD: begin
                    if (pwdata[15:0] <= servo_ctl_pkg::MAX_EST_METH) begin
                        est_meth_r <= pwdata[2:0];
                    end
                end
                servo_ctl_pkg::ADDR_FLT_METHOD: begin
                    if (pwdata[15:0] <= servo_ctl_pkg::MAX_EST_METH) begin
                        flt_meth_r <= pwdata[2:0];
                    end
                end
                servo_ctl_pkg::ADDR_FAST_TIME: fast_time_r <= pwdata[15:0];
                servo_ctl_pkg::ADDR_SLOW_TIME: slow_time_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (paddr)
            servo_ctl_pkg::ADDR_MODE_SEL:   rd_nxt[2:0]  = mode_sel_r;
            servo_ctl_pkg::ADDR_DIS_METHOD: rd_nxt[2:0]  = dis_meth_r;
            servo_ctl_pkg::ADDR_EST_METHOD: rd_nxt[2:0]  = est_meth_r;
            servo_ctl_pkg::ADDR_FLT_METHOD: rd_nxt[2:0]  = flt_meth_r;
            servo_ctl_pkg::ADDR_FAST_TIME:  rd_nxt[15:0] = fast_time_r;
            servo_ctl_pkg::ADDR_SLOW_TIME:  rd_nxt[15:0] = slow_time_r;
            servo_ctl_pkg::ADDR_STATUS: rd_nxt[11:0] = {tog1_s, tog0_s, flt_s, est_s,
                en_s, cause_r, state_r, active_mode};
            servo_ctl_pkg::ADDR_SPEED:      rd_nxt[SPW-1:0] = ramp_speed;
            default: ;
        endcase
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // Working mode from selector and toggles, live while running
    always_comb begin
        unique case (mode_sel_r)
            servo_ctl_pkg::SEL_POS: mode_nxt = servo_ctl_pkg::MODE_POS;
            servo_ctl_pkg::SEL_SPD: mode_nxt = servo_ctl_pkg::MODE_SPD;
            servo_ctl_pkg::SEL_TRQ: mode_nxt = servo_ctl_pkg::MODE_TRQ;
            servo_ctl_pkg::SEL_POS_TRQ:
                mode_nxt = tog0_s ? servo_ctl_pkg::MODE_TRQ : servo_ctl_pkg::MODE_POS;
            servo_ctl_pkg::SEL_POS_SPD:
                mode_nxt = tog0_s ? servo_ctl_pkg::MODE_SPD : servo_ctl_pkg::MODE_POS;
            servo_ctl_pkg::SEL_TRQ_SPD:
                mode_nxt = tog0_s ? servo_ctl_pkg::MODE_SPD : servo_ctl_pkg::MODE_TRQ;
            servo_ctl_pkg::SEL_TRIPLE:
                mode_nxt = tog1_s ? servo_ctl_pkg::MODE_POS :
                           tog0_s ? servo_ctl_pkg::MODE_TRQ : servo_ctl_pkg::MODE_SPD;
            default: mode_nxt = servo_ctl_pkg::MODE_SPC;
        endcase
    end

    // Cause by priority: fault, then emergency stop, then enable removal
    always_comb begin
        new_cause = flt_s ? servo_ctl_pkg::CAUSE_FAULT :
                    est_s ? servo_ctl_pkg::CAUSE_ESTOP :
                    !en_s ? servo_ctl_pkg::CAUSE_DIS : servo_ctl_pkg::CAUSE_NONE;
        new_meth  = new_cause == servo_ctl_pkg::CAUSE_FAULT ? flt_meth_r :
                    new_cause == servo_ctl_pkg::CAUSE_ESTOP ? est_meth_r : dis_meth_r;
        // Live lookup so a rewrite mid-stop applies at once
        meth      = cause_r == servo_ctl_pkg::CAUSE_FAULT ? flt_meth_r :
                    cause_r == servo_ctl_pkg::CAUSE_ESTOP ? est_meth_r : dis_meth_r;
        ramp_time = (meth == servo_ctl_pkg::METH_FAST_OFF ||
                     meth == servo_ctl_pkg::METH_FAST_HOLD) ? fast_time_r : slow_time_r;
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        ramp_load = 1'b0;
        unique case (state_r)
            servo_ctl_pkg::ST_IDLE: begin
                if (new_cause == servo_ctl_pkg::CAUSE_NONE) begin
                    state_nxt = servo_ctl_pkg::ST_RUN;
                end
            end
            servo_ctl_pkg::ST_RUN: begin
                if (new_cause != servo_ctl_pkg::CAUSE_NONE) begin
                    cause_nxt = new_cause;
                    if (new_meth == servo_ctl_pkg::METH_COAST) begin
                        state_nxt = new_cause == servo_ctl_pkg::CAUSE_DIS ?
                            servo_ctl_pkg::ST_IDLE : servo_ctl_pkg::ST_HALT;
                    end else begin
                        state_nxt = servo_ctl_pkg::ST_RAMP;
                        ramp_load = 1'b1;
                    end
                end
            end
            servo_ctl_pkg::ST_RAMP: begin
                if (flt_s && cause_r != servo_ctl_pkg::CAUSE_FAULT) begin
                    cause_nxt = servo_ctl_pkg::CAUSE_FAULT;
                end else if (meth == servo_ctl_pkg::METH_COAST) begin
                    state_nxt = cause_r == servo_ctl_pkg::CAUSE_DIS ?
                        servo_ctl_pkg::ST_IDLE : servo_ctl_pkg::ST_HALT;
                end else if (ramp_done) begin
                    if (meth >= servo_ctl_pkg::METH_FAST_HOLD) begin
                        state_nxt = servo_ctl_pkg::ST_HOLD;
                    end else begin
                        state_nxt = cause_r == servo_ctl_pkg::CAUSE_DIS ?
                            servo_ctl_pkg::ST_IDLE : servo_ctl_pkg::ST_HALT;
                    end
                end
            end
            servo_ctl_pkg::ST_HOLD: begin
                if (!en_s) begin
                    state_nxt = servo_ctl_pkg::ST_IDLE;
                end
            end
            servo_ctl_pkg::ST_HALT: begin
                // Enable must drop before a fresh start
                if (!en_s && !est_s && !flt_s) begin
                    state_nxt = servo_ctl_pkg::ST_IDLE;
                end
            end
            default: state_nxt = servo_ctl_pkg::ST_IDLE;
        endcase
        if (state_nxt == servo_ctl_pkg::ST_IDLE) begin
            cause_nxt = servo_ctl_pkg::CAUSE_NONE;
        end
    end

    // State and registered outputs, all but active_mode taken from the next state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r            <= servo_ctl_pkg::ST_IDLE;
            cause_r            <= servo_ctl_pkg::CAUSE_NONE;
            servo_ready_output <= 1'b0;
            cmd_accept         <= 1'b0;
            power_output_on    <= 1'b0;
            cmd_locked         <= 1'b0;
            active_mode        <= servo_ctl_pkg::MODE_POS;
        end else begin
            state_r            <= state_nxt;
            cause_r            <= cause_nxt;
            servo_ready_output <= state_nxt == servo_ctl_pkg::ST_RUN;
            cmd_accept         <= state_nxt == servo_ctl_pkg::ST_RUN;
            power_output_on    <= state_nxt == servo_ctl_pkg::ST_RUN ||
                                  state_nxt == servo_ctl_pkg::ST_RAMP ||
                                  state_nxt == servo_ctl_pkg::ST_HOLD;
            cmd_locked         <= state_nxt == servo_ctl_pkg::ST_HOLD;
            active_mode        <= mode_nxt;
        end
    end

    // Deceleration ramp
    stop_ramp #(
        .SPW        (SPW),
        .RATED      (RATED),
        .CYC_PER_MS (CYC_PER_MS)
    ) u_ramp (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (ramp_load),
        .run      (state_r == servo_ctl_pkg::ST_RAMP),
        .speed_in (speed_feedback),
        .time_ms  (ramp_time),
        .speed_r  (ramp_speed),
        .done_r   (ramp_done)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    enable_start_a: assert property (state_r == servo_ctl_pkg::ST_IDLE && en_s && !est_s
        && !flt_s |=> servo_ready_output && cmd_accept) else $error("no start");
    cmd_gate_a: assert property (cmd_accept |-> servo_ready_output && power_output_on)
        else $error("command taken while not ready");
    stop_cause_a: assert property (state_r == servo_ctl_pkg::ST_RUN && (est_s || flt_s)
        |=> !cmd_accept) else $error("stop ignored");
    coast_off_a: assert property (state_r == servo_ctl_pkg::ST_RUN && !en_s && !est_s
        && !flt_s && dis_meth_r == 3'h0 |=> !power_output_on
        && state_r == servo_ctl_pkg::ST_IDLE) else $error("coast kept power");
    ramp_power_a: assert property (state_r == servo_ctl_pkg::ST_RAMP |-> power_output_on)
        else $error("power lost during ramp");
    hold_lock_a: assert property (state_r == servo_ctl_pkg::ST_HOLD && en_s
        |=> cmd_locked && !cmd_accept && power_output_on) else $error("lock lost");
    estop_hold_a: assert property (state_r == servo_ctl_pkg::ST_RAMP && ramp_done
        && cause_r == servo_ctl_pkg::CAUSE_ESTOP && !flt_s && est_meth_r == 3'h3
        |=> state_r == servo_ctl_pkg::ST_HOLD) else $error("estop did not hold");
    dis_off_a: assert property (state_r == servo_ctl_pkg::ST_RAMP && ramp_done && !flt_s
        && cause_r == servo_ctl_pkg::CAUSE_DIS && dis_meth_r == 3'h1
        |=> !power_output_on) else $error("disable ramp kept power");
    hyb_speed_a: assert property (mode_sel_r == 3'h5 && tog0_s && !wr_en
        |=> active_mode == servo_ctl_pkg::MODE_SPD) else $error("hybrid mode");
    tri_pos_a: assert property (mode_sel_r == 3'h6 && tog1_s && !wr_en
        |=> active_mode == servo_ctl_pkg::MODE_POS) else $error("triple mode");
    ramp_falls_a: assert property (state_r == servo_ctl_pkg::ST_RAMP && ramp_speed != '0
        |=> ramp_speed <= $past(ramp_speed)) else $error("ramp rose");

    run_c: cover property (state_r == servo_ctl_pkg::ST_RUN);
    ramp_hold_c: cover property (state_r == servo_ctl_pkg::ST_RAMP
        ##1 state_r == servo_ctl_pkg::ST_HOLD);
    halt_c: cover property (state_r == servo_ctl_pkg::ST_HALT);
    apb_err_c: cover property (pready && pslverr);

endmodule : servo_mode_stop

//--- host_model.sv
/*
 * Host controller model: drives the servo input function bits on request.
 * Assumes the bench supplies request levels on pclk and the locked status.
 */
`timescale 1ns/1ns
module host_model (
    // Clock
    input  wire logic       pclk,
    // Requests from the bench
    input  wire logic       en_req,
    input  wire logic       est_req,
    input  wire logic       flt_req,
    input  wire logic [1:0] tog_req,
    // Device status
    input  wire logic       locked,
    // Function bits to the device
    output logic            en_pin,
    output logic            est_pin,
    output logic            flt_pin,
    output logic [1:0]      tog_pin
);
    logic rel_r;

    // Pins start inactive, the host has no reset of its own
    initial begin
        {en_pin, est_pin, flt_pin, tog_pin, rel_r} = '0;
    end

    // A locked drive is released by dropping enable until the bench withdraws it
    always @(posedge pclk) begin
        rel_r   <= (rel_r | locked) & en_req;
        en_pin  <= en_req & ~rel_r & ~locked;
        est_pin <= est_req;
        flt_pin <= flt_req;
        tog_pin <= tog_req;
    end
endmodule : host_model

//--- servo_mode_stop_tb_top.sv
/*
 * Self-checking bench: registers, mode table, every stop cause, all disable and estop methods, fault methods 0 and 1.
 * Assumes short ms count and low rated speed so ramps last 40 to 236 cycles.
 */
`timescale 1ns/1ns
module servo_mode_stop_tb_top;
    localparam int RATED = 100;
    localparam int CPM   = 10;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, ready, accept, power, locked, en, est, flt;
    logic        en_r = 1'b0, est_r = 1'b0, flt_r = 1'b0;
    logic [1:0]  tog_r = 2'h0, tog, mode;
    logic [15:0] spd = 16'h0000, rspd;
    int          error_cnt = 0, comparisons = 0, cyc = 0, i, s, k;
    logic [7:0]  ra [5] = '{servo_ctl_pkg::ADDR_MODE_SEL, servo_ctl_pkg::ADDR_DIS_METHOD,
        servo_ctl_pkg::ADDR_EST_METHOD, servo_ctl_pkg::ADDR_FAST_TIME,
        servo_ctl_pkg::ADDR_SLOW_TIME};
    logic [15:0] rv [5] = '{servo_ctl_pkg::RST_MODE_SEL, servo_ctl_pkg::RST_METHOD,
        servo_ctl_pkg::RST_METHOD, servo_ctl_pkg::RST_FAST_TIME, servo_ctl_pkg::RST_SLOW_TIME};
    int          cz [10] = '{0, 0, 0, 1, 1, 1, 1, 1, 2, 2};
    int          mt [10] = '{0, 1, 2, 0, 1, 2, 3, 4, 1, 0};

    servo_mode_stop #(.RATED(RATED), .CYC_PER_MS(CPM)) servo_mode_stop_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .servo_enable_input(en), .emergency_stop_input(est),
        .fault_input(flt), .mode_toggle_0(tog[0]), .mode_toggle_1(tog[1]),
        .speed_feedback(spd), .servo_ready_output(ready), .cmd_accept(accept),
        .power_output_on(power), .cmd_locked(locked), .active_mode(mode), .ramp_speed(rspd));

    host_model host_model_inst (
        .pclk(pclk), .en_req(en_r), .est_req(est_r), .flt_req(flt_r), .tog_req(tog_r),
        .locked(locked), .en_pin(en), .est_pin(est), .flt_pin(flt), .tog_pin(tog));

    // Clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for pready; only the bench timeout ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_ready();
        for (int n = 0; n < 50 && ready !== 1'b1; n++) @(posedge pclk);
    endtask : wait_ready

    function automatic logic [1:0] exp_mode(input int s, input logic [1:0] k);
        case (s)
            1: return 2'h1;
            2: return 2'h2;
            3: return k[0] ? 2'h2 : 2'h0;
            4: return k[0] ? 2'h1 : 2'h0;
            5: return k[0] ? 2'h1 : 2'h2;
            6: return k[1] ? 2'h0 : (k[0] ? 2'h2 : 2'h1);
            7: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction : exp_mode

    // Start, stop by cause c with method m, measure the stop and release
    task automatic stop_case(input int c, input int m);
        int n, e, v, pk;
        apb(1'b1, c == 0 ? servo_ctl_pkg::ADDR_DIS_METHOD : c == 1 ?
            servo_ctl_pkg::ADDR_EST_METHOD : servo_ctl_pkg::ADDR_FLT_METHOD, 32'(m));
        v = 20 + $urandom % 40;
        spd <= 16'(v);
        en_r <= 1'b1;
        wait_ready();
        check(32'(ready), 32'h1);
        check(32'(power), 32'h1);
        e = m == 0 ? 0 : v * ((m == 1 || m == 3) ? 20 : 40) * CPM / RATED;
        if (c == 0) en_r <= 1'b0;
        else if (c == 1) est_r <= 1'b1;
        else flt_r <= 1'b1;
        n = 0;
        pk = 0;
        while (n < 3000 && power === 1'b1 && locked !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (int'(rspd) > pk) pk = int'(rspd);
        end
        check(32'(n >= e && n <= e + 10), 32'h1);
        check(32'(pk), 32'(m == 0 ? 0 : v));
        check({16'h0000, rspd}, 32'h0);
        check(32'(accept), 32'h0);
        check(32'(locked), 32'(c == 1 && m > 2));
        check(32'(power), 32'(c == 1 && m > 2));
        {en_r, est_r, flt_r} <= 3'h0;
        repeat (8) @(posedge pclk);
        check(32'(power), 32'h0);
    endtask : stop_case

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        void'($urandom(35877));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, {16'h0000, rv[i]});
        end
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, servo_ctl_pkg::ADDR_MODE_SEL, 32'h8);
        apb(1'b0, servo_ctl_pkg::ADDR_MODE_SEL, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, servo_ctl_pkg::ADDR_DIS_METHOD, 32'h3);
        apb(1'b0, servo_ctl_pkg::ADDR_DIS_METHOD, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, servo_ctl_pkg::ADDR_FAST_TIME, 32'h14);
        apb(1'b1, servo_ctl_pkg::ADDR_SLOW_TIME, 32'h28);
        check(32'(accept), 32'h0);
        en_r <= 1'b1;
        wait_ready();
        check(32'(accept), 32'h1);
        // Mode changes land while the drive runs
        for (s = 0; s < 8; s++) begin
            for (k = 0; k < 4; k++) begin
                apb(1'b1, servo_ctl_pkg::ADDR_MODE_SEL, 32'(s));
                tog_r <= 2'(k);
                repeat (5) @(posedge pclk);
                check(32'(mode), 32'(exp_mode(s, 2'(k))));
            end
        end
        en_r <= 1'b0;
        repeat (8) @(posedge pclk);
        for (i = 0; i < 10; i++) stop_case(cz[i], mt[i]);
        test_done();
    end
endmodule : servo_mode_stop_tb_top
